// File: pin_mux_consts.svh
// Constants of the external memory pad multiplexer.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define OWN_CODE_NONE 3'h0
`define OWN_CODE_STATIC 3'h1
`define OWN_CODE_SDRAM 3'h2
`define OWN_CODE_CARD 3'h3
`define OWN_CODE_DDR 3'h4
`define OWN_CODE_NAND 3'h5
`define ADDR_PAD_IDLE 26'h0000000
`define ADDR_HI_IDLE 12'h000
`define STROBE_IDLE 1'b1
`define LEVEL_IDLE 1'b0
`define CHIP_SEL_IDLE 6'h3F
`define MASK_IDLE 4'h0
`define NAND_IDLE 6'h23
`define CARD_CTRL_RST 4'h0
`define CARD_STATUS_RST 9'h000
`define CARD_PWR_BIT 0
`define CARD_RST_BIT 1
`define CARD_RW_BIT 2
`define CARD_OE_BIT 3
`define NAND_WE_BIT 0
`define NAND_RE_BIT 1
`define NAND_ALE_BIT 2
`define NAND_CLE_BIT 3
`define NAND_WP_BIT 4
`define NAND_CE_BIT 5
`endif

// File: pin_mux_pkg.sv
// Types of the external memory pad multiplexer.
package pin_mux_pkg;
  typedef enum logic [5:0] {
    OWNER_IDLE = 6'h01,
    OWNER_STATIC = 6'h02,
    OWNER_SDRAM = 6'h04,
    OWNER_CARD = 6'h08,
    OWNER_DDR = 6'h10,
    OWNER_NAND = 6'h20
  } owner_t;
endpackage : pin_mux_pkg

// File: lane_if.sv
// Carrier between the pad multiplexer and one shared data lane.
`timescale 1ns/1ns
interface lane_if #(parameter int W = 16, parameter int N = 3);
  logic [N-1:0] sel;
  logic [W-1:0] src_out [N];
  logic [N-1:0] src_oe;
  logic [W-1:0] pad_in;
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe;
  logic [W-1:0] rd_data;
  modport top (output sel, output src_out, output src_oe, output pad_in,
    input pad_out, input pad_oe, input rd_data);
  modport lane (input sel, input src_out, input src_oe, input pad_in,
    output pad_out, output pad_oe, output rd_data);
endinterface : lane_if

// File: data_lane_mux.sv
// One shared bidirectional data lane: picks its single driver and returns read data.
`timescale 1ns/1ns
module data_lane_mux #(
  parameter int W = 16,
  parameter int N = 3
) (
  input wire logic ref_clk,
  input wire logic nrst,
  lane_if.lane l
);
  logic [W-1:0] out_next;
  logic oe_next;

  // Only the selected source reaches the pad, so no two owners drive it.
  always_comb
  begin
    out_next = '0;
    oe_next = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (l.sel[i])
      begin
        out_next = out_next | l.src_out[i];
        oe_next = oe_next | l.src_oe[i];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      l.pad_out <= '0;
      l.pad_oe <= '0;
      l.rd_data <= '0;
    end
    else
    begin
      l.pad_out <= out_next;
      l.pad_oe <= {W{oe_next}};
      l.rd_data <= l.pad_in;
    end
  end
endmodule : data_lane_mux

// File: ext_memory_pin_mux.sv
// Pad multiplexer that shares the external memory pads among five memory controllers.
// Function
// - Pad sharing among the five memory controllers is done here, in this module and its data_lane_mux instances.
// - Address pads 0-9 and 11-13 carry same-index bit for every address user.
// - Address pad 10 serves static and card; a dedicated pad carries SDRAM/DDR bit 10.
// - Address pads 14-25 are driven only for static and card accesses.
// - Bank pads carry bank select for SDRAM, card enables 1 and 2 for card.
// - SDRAM uses the 32 wide data pads and four data masks.
// - The four data strobes serve only DDR, one per byte lane.
// - Byte enables and output enable become REG, IORD, IOWR in card mode.
// - Load-address and read/write pads become card output and write enable.
// - Six static chip selects; 2 and 3 carry SDRAM chip selects in SDRAM mode.
// - Row, column, write enable, clock enables and clock pads serve only SDRAM.
// - Seven dedicated NAND pads serve only the NAND controller.
// - Data pads 0-15 are shared by static, card and NAND only.
// - Dedicated card pads serve only the card controller.
// - Burst clock, end of burst and load-address pads serve static memory.
`timescale 1ns/1ns
`include "pin_mux_consts.svh"
module ext_memory_pin_mux (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] owner_req,
  input wire logic [25:0] static_addr,
  input wire logic [1:0] static_byte_en,
  input wire logic static_out_en,
  input wire logic static_load_addr,
  input wire logic static_rw,
  input wire logic [5:0] static_chip_sel,
  input wire logic static_burst_clk,
  input wire logic [15:0] static_wdata,
  input wire logic static_wdata_oe,
  output logic static_end_burst,
  input wire logic [13:0] sdram_addr,
  input wire logic [1:0] sdram_bank,
  input wire logic [1:0] sdram_cs,
  input wire logic sdram_ras,
  input wire logic sdram_cas,
  input wire logic sdram_we,
  input wire logic [1:0] sdram_cke,
  input wire logic sdram_clk,
  input wire logic [3:0] sdram_mask,
  input wire logic [31:0] sdram_wdata,
  input wire logic sdram_wdata_oe,
  input wire logic [13:0] ddr_addr,
  input wire logic [31:0] ddr_wdata,
  input wire logic ddr_wdata_oe,
  input wire logic [3:0] ddr_strobe,
  input wire logic ddr_strobe_oe,
  output logic [3:0] ddr_strobe_rd,
  output logic [31:0] wide_rdata,
  input wire logic [25:0] card_addr,
  input wire logic card_en1,
  input wire logic card_en2,
  input wire logic card_reg,
  input wire logic card_iord,
  input wire logic card_iowr,
  input wire logic card_oe,
  input wire logic card_we,
  input wire logic [15:0] card_wdata,
  input wire logic card_wdata_oe,
  input wire logic [3:0] card_ctrl,
  output logic [8:0] card_status,
  input wire logic [5:0] nand_ctrl,
  input wire logic [15:0] nand_wdata,
  input wire logic nand_wdata_oe,
  output logic nand_ready,
  output logic [15:0] data_rdata,
  output logic [25:0] addr_pad,
  output logic mem_addr10,
  output logic sdram_bank_sel_hi,
  output logic sdram_bank_sel_lo,
  output logic [31:0] wide_data_out,
  output logic [31:0] wide_data_oe,
  input wire logic [31:0] wide_data_in,
  output logic [3:0] data_mask_pad,
  output logic [3:0] ddr_strobe_lane_out,
  output logic [3:0] ddr_strobe_lane_oe,
  input wire logic [3:0] ddr_strobe_lane_in,
  output logic byte_enable_lo,
  output logic byte_enable_hi,
  output logic out_en_pad,
  output logic load_burst_address,
  output logic rw_pad,
  output logic [5:0] chip_sel_pad,
  input wire logic end_current_burst,
  output logic burst_clk_pad,
  output logic row_strobe,
  output logic col_strobe,
  output logic sdram_write_en,
  output logic sdram_clk_en0,
  output logic sdram_clk_en1,
  output logic sdram_clk_pad,
  output logic nand_write_en,
  output logic nand_read_en,
  output logic nand_addr_latch,
  output logic nand_cmd_latch,
  output logic nand_write_protect,
  output logic nand_chip_en,
  input wire logic nand_ready_busy,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  input wire logic [15:0] data_in,
  output logic card_power_on,
  output logic card_reset_pad,
  output logic card_rw_pad,
  output logic card_output_en,
  input wire logic [1:0] card_detect,
  input wire logic card_wait,
  input wire logic card_ready,
  input wire logic [1:0] card_vsense,
  input wire logic [1:0] card_bvd,
  input wire logic card_iois16
);
  pin_mux_pkg::owner_t owner_reg;
  pin_mux_pkg::owner_t owner_next;
  lane_if #(.W(16), .N(3)) narrow_lane ();
  lane_if #(.W(32), .N(2)) wide_lane ();
  lane_if #(.W(4), .N(1)) strobe_lane ();

  // Owner decode; an unknown request parks the pads.
  always_comb
  begin
    case (owner_req)
      `OWN_CODE_STATIC: owner_next = pin_mux_pkg::OWNER_STATIC;
      `OWN_CODE_SDRAM: owner_next = pin_mux_pkg::OWNER_SDRAM;
      `OWN_CODE_CARD: owner_next = pin_mux_pkg::OWNER_CARD;
      `OWN_CODE_DDR: owner_next = pin_mux_pkg::OWNER_DDR;
      `OWN_CODE_NAND: owner_next = pin_mux_pkg::OWNER_NAND;
      default: owner_next = pin_mux_pkg::OWNER_IDLE;
    endcase
  end

  wire sel_static = owner_reg == pin_mux_pkg::OWNER_STATIC;
  wire sel_sdram = owner_reg == pin_mux_pkg::OWNER_SDRAM;
  wire sel_card = owner_reg == pin_mux_pkg::OWNER_CARD;
  wire sel_ddr = owner_reg == pin_mux_pkg::OWNER_DDR;
  wire sel_nand = owner_reg == pin_mux_pkg::OWNER_NAND;
  wire sel_async = sel_static | sel_card;
  wire sel_row_col = sel_sdram | sel_ddr;
  wire [25:0] async_addr = sel_static ? static_addr : card_addr;
  wire [13:0] row_col_addr = sel_sdram ? sdram_addr : ddr_addr;

  // Address pads: 0-9 and 11-13 shared, 10 split, 14-25 asynchronous only.
  wire [25:0] addr_pad_next = sel_async ? async_addr :
    sel_row_col ? {`ADDR_HI_IDLE, row_col_addr[13:11], `LEVEL_IDLE, row_col_addr[9:0]} :
    `ADDR_PAD_IDLE;
  wire mem_addr10_next = sel_row_col ? row_col_addr[10] : `LEVEL_IDLE;
  wire bank_hi_next = sel_sdram ? sdram_bank[1] : sel_card ? card_en1 : `STROBE_IDLE;
  wire bank_lo_next = sel_sdram ? sdram_bank[0] : sel_card ? card_en2 : `STROBE_IDLE;
  wire [2:0] be_oe_next = sel_static ? {static_out_en, static_byte_en} :
    sel_card ? {card_iowr, card_iord, card_reg} : {3{`STROBE_IDLE}};
  wire lba_next = sel_static ? static_load_addr : sel_card ? card_oe : `STROBE_IDLE;
  wire rw_next = sel_static ? static_rw : sel_card ? card_we : `STROBE_IDLE;
  wire [5:0] cs_next = sel_static ? static_chip_sel :
    sel_sdram ? {2'h3, sdram_cs, 2'h3} : `CHIP_SEL_IDLE;
  wire bclk_next = sel_static ? static_burst_clk : `LEVEL_IDLE;
  wire end_burst_next = sel_static ? end_current_burst : `STROBE_IDLE;
  wire [2:0] sdram_cmd_next = sel_sdram ? {sdram_we, sdram_cas, sdram_ras} : {3{`STROBE_IDLE}};
  wire [2:0] sdram_clk_next = sel_sdram ? {sdram_clk, sdram_cke} : {3{`LEVEL_IDLE}};
  wire [3:0] mask_next = sel_sdram ? sdram_mask : `MASK_IDLE;
  wire [5:0] nand_idle = `NAND_IDLE;
  wire [5:0] nand_next = sel_nand ? nand_ctrl : nand_idle;

  // Shared data lanes; each lane keeps one driver at a time.
  assign narrow_lane.sel = {sel_nand, sel_card, sel_static};
  assign narrow_lane.src_out[0] = static_wdata;
  assign narrow_lane.src_out[1] = card_wdata;
  assign narrow_lane.src_out[2] = nand_wdata;
  assign narrow_lane.src_oe = {nand_wdata_oe, card_wdata_oe, static_wdata_oe};
  assign narrow_lane.pad_in = data_in;
  assign wide_lane.sel = {sel_ddr, sel_sdram};
  assign wide_lane.src_out[0] = sdram_wdata;
  assign wide_lane.src_out[1] = ddr_wdata;
  assign wide_lane.src_oe = {ddr_wdata_oe, sdram_wdata_oe};
  assign wide_lane.pad_in = wide_data_in;
  assign strobe_lane.sel = sel_ddr;
  assign strobe_lane.src_out[0] = ddr_strobe;
  assign strobe_lane.src_oe = ddr_strobe_oe;
  assign strobe_lane.pad_in = ddr_strobe_lane_in;

  data_lane_mux #(.W(16), .N(3)) u_narrow (.ref_clk(ref_clk), .nrst(nrst), .l(narrow_lane));
  data_lane_mux #(.W(32), .N(2)) u_wide (.ref_clk(ref_clk), .nrst(nrst), .l(wide_lane));
  data_lane_mux #(.W(4), .N(1)) u_strobe (.ref_clk(ref_clk), .nrst(nrst), .l(strobe_lane));

  assign data_out = narrow_lane.pad_out;
  assign data_oe = narrow_lane.pad_oe;
  assign data_rdata = narrow_lane.rd_data;
  assign wide_data_out = wide_lane.pad_out;
  assign wide_data_oe = wide_lane.pad_oe;
  assign wide_rdata = wide_lane.rd_data;
  assign ddr_strobe_lane_out = strobe_lane.pad_out;
  assign ddr_strobe_lane_oe = strobe_lane.pad_oe;
  assign ddr_strobe_rd = strobe_lane.rd_data;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      owner_reg <= pin_mux_pkg::OWNER_IDLE;
      addr_pad <= `ADDR_PAD_IDLE;
      mem_addr10 <= `LEVEL_IDLE;
      sdram_bank_sel_hi <= `STROBE_IDLE;
      sdram_bank_sel_lo <= `STROBE_IDLE;
      {out_en_pad, byte_enable_hi, byte_enable_lo} <= {3{`STROBE_IDLE}};
      load_burst_address <= `STROBE_IDLE;
      rw_pad <= `STROBE_IDLE;
      chip_sel_pad <= `CHIP_SEL_IDLE;
      burst_clk_pad <= `LEVEL_IDLE;
      static_end_burst <= `STROBE_IDLE;
      {sdram_write_en, col_strobe, row_strobe} <= {3{`STROBE_IDLE}};
      {sdram_clk_pad, sdram_clk_en1, sdram_clk_en0} <= {3{`LEVEL_IDLE}};
      data_mask_pad <= `MASK_IDLE;
      {nand_chip_en, nand_write_protect, nand_cmd_latch, nand_addr_latch, nand_read_en, nand_write_en} <= nand_idle;
      nand_ready <= `LEVEL_IDLE;
      {card_output_en, card_rw_pad, card_reset_pad, card_power_on} <= `CARD_CTRL_RST;
      card_status <= `CARD_STATUS_RST;
    end
    else
    begin
      owner_reg <= owner_next;
      addr_pad <= addr_pad_next;
      mem_addr10 <= mem_addr10_next;
      sdram_bank_sel_hi <= bank_hi_next;
      sdram_bank_sel_lo <= bank_lo_next;
      {out_en_pad, byte_enable_hi, byte_enable_lo} <= be_oe_next;
      load_burst_address <= lba_next;
      rw_pad <= rw_next;
      chip_sel_pad <= cs_next;
      burst_clk_pad <= bclk_next;
      static_end_burst <= end_burst_next;
      {sdram_write_en, col_strobe, row_strobe} <= sdram_cmd_next;
      {sdram_clk_pad, sdram_clk_en1, sdram_clk_en0} <= sdram_clk_next;
      data_mask_pad <= mask_next;
      {nand_chip_en, nand_write_protect, nand_cmd_latch, nand_addr_latch, nand_read_en, nand_write_en} <= nand_next;
      nand_ready <= nand_ready_busy;
      {card_output_en, card_rw_pad, card_reset_pad, card_power_on} <= card_ctrl;
      card_status <= {card_iois16, card_bvd, card_vsense, card_ready, card_wait, card_detect};
    end
  end

  owner_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    owner_req == `OWN_CODE_STATIC |=> owner_reg == pin_mux_pkg::OWNER_STATIC)
    else $error("Owner did not follow the request.");
  addr_high_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sel_sdram || sel_ddr || sel_nand) |=> addr_pad[25:14] == 12'h000)
    else $error("Upper address pads driven outside asynchronous modes.");
  addr10_split_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_ddr |=> addr_pad[10] == 1'b0 && mem_addr10 == $past(ddr_addr[10]))
    else $error("Address bit 10 took the wrong pad.");
  addr_shared_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_sdram |=> addr_pad[9:0] == $past(sdram_addr[9:0]) && addr_pad[13:11] == $past(sdram_addr[13:11]))
    else $error("Shared address pads wrong in SDRAM mode.");
  bank_card_map_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_card |=> sdram_bank_sel_hi == $past(card_en1) && sdram_bank_sel_lo == $past(card_en2))
    else $error("Card enables not on bank pads.");
  chip_sel_sdram_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_sdram |=> chip_sel_pad == {2'h3, $past(sdram_cs), 2'h3})
    else $error("Chip select pads wrong in SDRAM mode.");
  card_strobes_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_card |=> byte_enable_lo == $past(card_reg) && out_en_pad == $past(card_iowr))
    else $error("Card strobes not on byte enable pads.");
  strobe_ddr_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sel_ddr |=> ddr_strobe_lane_oe == 4'h0)
    else $error("Data strobe driven outside DDR mode.");
  data_oe_excl_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_row_col |=> data_oe == 16'h0000)
    else $error("Narrow data pads driven in SDRAM or DDR mode.");
  wide_oe_excl_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sel_async || sel_nand) |=> wide_data_oe == 32'h00000000)
    else $error("Wide data pads driven outside SDRAM or DDR mode.");
  nand_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sel_nand |=> nand_chip_en && nand_write_en && nand_read_en)
    else $error("NAND pads active without NAND ownership.");
  sdram_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sel_sdram |=> row_strobe && col_strobe && !sdram_clk_en0 && !sdram_clk_pad)
    else $error("SDRAM pads active without SDRAM ownership.");
  cover_card_c: cover property (@(posedge ref_clk) disable iff (!nrst) sel_card ##1 sel_ddr);
  cover_ddr_c: cover property (@(posedge ref_clk) disable iff (!nrst) sel_ddr && ddr_strobe_oe);
  cover_sdram_c: cover property (@(posedge ref_clk) disable iff (!nrst) sel_sdram ##1 sel_card);
endmodule : ext_memory_pin_mux

// File: ext_mem_model.sv
// Behavioural model of the memories and cards on the shared external pads.
`timescale 1ns/1ns
module ext_mem_model (
  input wire logic ref_clk,
  input wire logic [31:0] wide_data_out,
  input wire logic [31:0] wide_data_oe,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic [3:0] ddr_strobe_lane_out,
  input wire logic [3:0] ddr_strobe_lane_oe,
  output logic [31:0] wide_data_in,
  output logic [15:0] data_in,
  output logic [3:0] ddr_strobe_lane_in,
  output logic [10:0] status_pads
);
  logic [31:0] pat = 32'h6A09E667;

  // Released lines and status pins change every cycle so stale values never pass.
  always @(posedge ref_clk)
    pat <= pat * 32'h0019660D + 32'h3C6EF35F;

  // Each pad shows the level of whichever party drives it.
  assign data_in = (data_oe & data_out) | (~data_oe & pat[15:0]);
  assign wide_data_in = (wide_data_oe & wide_data_out) | (~wide_data_oe & ~pat);
  assign ddr_strobe_lane_in = (ddr_strobe_lane_oe & ddr_strobe_lane_out) | (~ddr_strobe_lane_oe & pat[23:20]);
  assign status_pads = pat[30:20];
endmodule : ext_mem_model

// File: ext_memory_pin_mux_tb.sv
// Self-checking testbench of the external memory pad multiplexer.
`timescale 1ns/1ns
module ext_memory_pin_mux_tb;
  logic ref_clk, nrst, static_out_en, static_load_addr, static_rw, static_burst_clk, static_wdata_oe;
  logic static_end_burst, sdram_ras, sdram_cas, sdram_we, sdram_clk, sdram_wdata_oe, ddr_wdata_oe, ddr_strobe_oe;
  logic card_en1, card_en2, card_reg, card_iord, card_iowr, card_oe, card_we, card_wdata_oe, nand_wdata_oe;
  logic nand_ready, mem_addr10, sdram_bank_sel_hi, sdram_bank_sel_lo, byte_enable_lo, byte_enable_hi, out_en_pad;
  logic load_burst_address, rw_pad, end_current_burst, burst_clk_pad, row_strobe, col_strobe, sdram_write_en;
  logic sdram_clk_en0, sdram_clk_en1, sdram_clk_pad, nand_write_en, nand_read_en, nand_addr_latch, nand_cmd_latch;
  logic nand_write_protect, nand_chip_en, nand_ready_busy, card_power_on, card_reset_pad, card_rw_pad;
  logic card_output_en, card_wait, card_ready, card_iois16;
  logic [1:0] static_byte_en, sdram_bank, sdram_cs, sdram_cke, card_detect, card_vsense, card_bvd;
  logic [2:0] owner_req;
  logic [3:0] sdram_mask, ddr_strobe, ddr_strobe_rd, data_mask_pad, ddr_strobe_lane_out, ddr_strobe_lane_oe;
  logic [3:0] ddr_strobe_lane_in, card_ctrl;
  logic [5:0] static_chip_sel, nand_ctrl, chip_sel_pad;
  logic [8:0] card_status;
  logic [10:0] status_pads;
  logic [13:0] sdram_addr, ddr_addr;
  logic [15:0] static_wdata, card_wdata, nand_wdata, data_rdata, data_out, data_oe, data_in;
  logic [25:0] static_addr, card_addr, addr_pad;
  logic [31:0] sdram_wdata, ddr_wdata, wide_rdata, wide_data_out, wide_data_oe, wide_data_in, seed;
  logic [255:0] stim;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  // Every controller input is spread from one seed, so each scenario moves all of them.
  assign stim = {seed, ~seed, seed ^ 32'h5A5A5A5A, {seed[15:0], seed[31:16]}, seed + 32'h13579BDF,
    ~seed ^ 32'h0F0F0F0F, seed * 32'h3, seed ^ 32'hFFFF0000};
  assign {static_addr, static_byte_en, static_out_en, static_load_addr, static_rw, static_chip_sel, static_burst_clk,
    static_wdata, static_wdata_oe, sdram_addr, sdram_bank, sdram_cs, sdram_ras, sdram_cas, sdram_we, sdram_cke,
    sdram_clk, sdram_mask, sdram_wdata, sdram_wdata_oe, ddr_addr, ddr_wdata, ddr_wdata_oe, ddr_strobe,
    ddr_strobe_oe, card_addr, card_en1, card_en2, card_reg, card_iord, card_iowr, card_oe, card_we, card_wdata,
    card_wdata_oe, card_ctrl, nand_ctrl, nand_wdata, nand_wdata_oe} = stim[244:0];
  assign {end_current_burst, nand_ready_busy, card_iois16, card_bvd, card_vsense, card_ready, card_wait,
    card_detect} = status_pads;

  ext_memory_pin_mux ext_memory_pin_mux_i (.*);
  ext_mem_model ext_mem_model_i (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: pad value %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic check_pads(input logic [2:0] code);
    logic s, sd, c, d, n, dx, wx;
    logic [4:0] sg;
    logic [5:0] nd;
    logic [13:0] m;
    logic [25:0] ea;
    s = code == 3'h1;
    sd = code == 3'h2;
    c = code == 3'h3;
    d = code == 3'h4;
    n = code == 3'h5;
    m = sd ? sdram_addr : ddr_addr;
    ea = s ? static_addr : c ? card_addr : (sd | d) ? {12'h000, m[13:11], 1'b0, m[9:0]} : 26'h0000000;
    sg = c ? {card_reg, card_iord, card_iowr, card_oe, card_we} : 5'h1F;
    if (s) sg = {static_byte_en[0], static_byte_en[1], static_out_en, static_load_addr, static_rw};
    nd = {nand_chip_en, nand_write_protect, nand_cmd_latch, nand_addr_latch, nand_read_en, nand_write_en};
    dx = s ? static_wdata_oe : c ? card_wdata_oe : n & nand_wdata_oe;
    wx = sd ? sdram_wdata_oe : d & ddr_wdata_oe;
    chk(addr_pad, ea);
    chk(mem_addr10, (sd | d) & m[10]);
    chk({sdram_bank_sel_hi, sdram_bank_sel_lo}, sd ? sdram_bank : c ? {card_en1, card_en2} : 2'h3);
    chk({byte_enable_lo, byte_enable_hi, out_en_pad, load_burst_address, rw_pad}, sg);
    chk(chip_sel_pad, s ? static_chip_sel : sd ? {2'h3, sdram_cs, 2'h3} : 6'h3F);
    chk(burst_clk_pad, s & static_burst_clk);
    chk({row_strobe, col_strobe, sdram_write_en}, sd ? {sdram_ras, sdram_cas, sdram_we} : 3'h7);
    chk({sdram_clk_en0, sdram_clk_en1, sdram_clk_pad}, sd ? {sdram_cke[0], sdram_cke[1], sdram_clk} : 3'h0);
    chk(data_mask_pad, sd ? sdram_mask : 4'h0);
    chk(nd, n ? nand_ctrl : 6'h23);
    chk(data_oe, {16{dx}});
    if (dx) chk(data_out, s ? static_wdata : c ? card_wdata : nand_wdata);
    chk(wide_data_oe, {32{wx}});
    if (wx) chk(wide_data_out, sd ? sdram_wdata : ddr_wdata);
    chk(ddr_strobe_lane_oe, {4{d & ddr_strobe_oe}});
    if (d & ddr_strobe_oe) chk(ddr_strobe_lane_out, ddr_strobe);
  endtask : check_pads

  task automatic check_inputs(input logic [2:0] code);
    logic [15:0] dq;
    logic [31:0] w;
    logic [3:0] q;
    logic [10:0] st;
    @(negedge ref_clk);
    dq = data_in;
    w = wide_data_in;
    q = ddr_strobe_lane_in;
    st = status_pads;
    @(posedge ref_clk);
    #1;
    chk(data_rdata, dq);
    chk(wide_rdata, w);
    chk(ddr_strobe_rd, q);
    chk(card_status, st[8:0]);
    chk(nand_ready, st[9]);
    chk(static_end_burst, code == 3'h1 ? st[10] : 1'b1);
    chk({card_output_en, card_rw_pad, card_reset_pad, card_power_on}, card_ctrl);
  endtask : check_inputs

  task automatic check_reset();
    check_pads(3'h0);
    chk(card_status, 32'h00000000);
    chk(data_rdata, 32'h00000000);
    chk(wide_rdata, 32'h00000000);
    chk({ddr_strobe_rd, nand_ready}, 32'h00000000);
    chk({static_end_burst, card_output_en, card_rw_pad, card_reset_pad, card_power_on}, 32'h00000010);
  endtask : check_reset

  task automatic apply(input logic [2:0] code, input logic [31:0] v);
    @(posedge ref_clk);
    owner_req <= code;
    seed <= v;
    repeat (2) @(posedge ref_clk);
    #1;
    check_pads(code);
    check_inputs(code);
  endtask : apply

  task automatic test_owners();
    for (int k = 1; k <= 5; k++)
    begin
      apply(k[2:0], 32'h8E3A5C71 ^ (k * 32'h01234567));
      apply(k[2:0], 32'h71C5A38E + (k * 32'h00FEDCBA));
    end
  endtask : test_owners

  task automatic test_refused();
    apply(3'h0, 32'hDEADBEEF);
    apply(3'h6, 32'h0BADF00D);
    apply(3'h7, 32'hFFFFFFFF);
  endtask : test_refused

  task automatic test_back_to_back();
    @(posedge ref_clk);
    owner_req <= 3'h1;
    seed <= 32'hC0FFEE11;
    @(posedge ref_clk);
    owner_req <= 3'h2;
    @(posedge ref_clk);
    owner_req <= 3'h3;
    #1;
    check_pads(3'h1);
    @(posedge ref_clk);
    #1;
    check_pads(3'h2);
    @(posedge ref_clk);
    #1;
    check_pads(3'h3);
  endtask : test_back_to_back

  task automatic test_mid_reset();
    apply(3'h2, 32'h3FFFFFFF);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check_reset();
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check_pads(3'h2);
  endtask : test_mid_reset

  initial
  begin
    nrst = 1'b0;
    owner_req = 3'h0;
    seed = 32'h5555AAAA;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    check_reset();
    test_owners();
    test_refused();
    test_back_to_back();
    test_mid_reset();
    print_verdict();
  end
endmodule : ext_memory_pin_mux_tb
